// ---- core/pf_consts.vh ----
// Constants for the power factor underlimit protection stage
`ifndef PF_CONSTS_VH
`define PF_CONSTS_VH

// Processing step and clock
`define PF_CLK_PERIOD_NS 5
`define PF_STEP_NS 5000000
`define PF_STEP_CYCLES (`PF_STEP_NS / `PF_CLK_PERIOD_NS)

// Widths
`define PF_W 7
`define PF_DLY_W 19
`define PF_RATIO_W 12
`define PF_TS_W 32

// Register byte offsets
`define PF_REG_CTRL 8'h00
`define PF_REG_TRIP_THR 8'h04
`define PF_REG_ALARM_THR 8'h08
`define PF_REG_TRIP_DLY 8'h0C
`define PF_REG_ALARM_DLY 8'h10
`define PF_REG_REL_DLY 8'h14
`define PF_REG_STATUS 8'h18
`define PF_REG_TTA 8'h1C
`define PF_REG_TTT 8'h20
`define PF_REG_EXP_ALARM 8'h24
`define PF_REG_EXP_TRIP 8'h28
`define PF_REG_RATIO_TRIP 8'h2C
`define PF_REG_RATIO_ALARM 8'h30
`define PF_REG_EVT_SEL 8'h34
`define PF_REG_REC_IDX 8'h38
`define PF_REG_REC_PF 8'h3C
`define PF_REG_REC_INFO 8'h40

// Control register fields
`define PF_CTRL_MODE_LSB 0
`define PF_CTRL_ALARMS_BIT 4
`define PF_CTRL_FORCE_EN_BIT 8
`define PF_CTRL_FORCE_LSB 9
`define PF_CTRL_LN_VIS_BIT 12

// Function modes
`define PF_MODE_ON 3'h0
`define PF_MODE_BLOCKED 3'h1
`define PF_MODE_TEST 3'h2
`define PF_MODE_TEST_BLK 3'h3
`define PF_MODE_OFF 3'h4

// Condition codes
`define PF_ST_NORMAL 3'h0
`define PF_ST_START 3'h1
`define PF_ST_TRIP 3'h2
`define PF_ST_BLOCKED 3'h3
`define PF_ST_ALARM_START 3'h4
`define PF_ST_ALARM 3'h5

// Reset values and threshold clamp limits
`define PF_TRIP_THR_RST 7'h50
`define PF_ALARM_THR_RST 7'h5A
`define PF_THR_MIN 7'h05
`define PF_THR_MAX 7'h63
`define PF_TRIP_DLY_RST 19'h000C8
`define PF_ALARM_DLY_RST 19'h000C8
`define PF_REL_DLY_RST 19'h00001
`define PF_EVT_SEL_RST 20'hFFFFF

// Release hysteresis in percent of threshold
`define PF_HYST_PCT 7'h67

// History offsets in steps: -20 ms and -200 ms before newest sample
`define PF_PRE_TRIG_STEPS 6'h05
`define PF_PRE_FAULT_STEPS 6'h29
`define PF_REC_DEPTH 12

`endif

// ---- core/pf_ratio_div.v ----
// Restoring divider giving measured power factor over threshold, 0.01 units
`timescale 1ns/1ps
module pf_ratio_div (
    input wire clk_in,
    input wire rstn_in,
    input wire start_in,
    input wire [6:0] pf_in,
    input wire [6:0] thr_in,
    output reg [11:0] ratio_out
);
    reg [13:0] quo_q;
    reg [6:0] rem_q;
    reg [6:0] den_q;
    reg [3:0] cnt_q;
    wire [7:0] trial;
    wire take;

    // Next partial remainder and quotient bit
    assign trial = {rem_q, quo_q[13]};
    assign take = (trial >= {1'b0, den_q});

    // Dividend is pf*100 (up to 10000, so 14 bits); quotient keeps decimals
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            quo_q <= 14'h0000;
            rem_q <= 7'h00;
            den_q <= 7'h01;
            cnt_q <= 4'h0;
            ratio_out <= 12'h000;
        end else if (start_in) begin
            quo_q <= {7'h00, pf_in} * 14'h0064;
            rem_q <= 7'h00;
            den_q <= (thr_in == 7'h00) ? 7'h01 : thr_in; // Never divide by 0
            cnt_q <= 4'hE;
        end else if (cnt_q != 4'h0) begin
            rem_q <= take ? trial[6:0] - den_q : trial[6:0];
            quo_q <= {quo_q[12:0], take};
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
                ratio_out <= {quo_q[10:0], take}; // At most 2000, fits
            end
        end
    end
endmodule // pf_ratio_div

// ---- core/pf_record_store.v ----
// Power factor history and circular store of the last twelve fault records
`timescale 1ns/1ps
`include "pf_consts.vh"
module pf_record_store (
    input wire clk_in,
    input wire rstn_in,
    input wire tick_in,
    input wire [6:0] pf_in,
    input wire wr_in,
    input wire [2:0] code_in,
    input wire [18:0] remain_in,
    input wire [3:0] rd_idx_in,
    output wire [20:0] rd_pf_out,
    output wire [22:0] rd_info_out,
    output wire [3:0] count_out
);
    reg [6:0] hist [0:63];
    reg [5:0] hptr_q;
    reg [5:0] hfill_q;
    reg [20:0] rec_pf [0:11];
    reg [21:0] rec_info [0:11];
    reg [3:0] wptr_q;
    reg [3:0] cnt_q;
    wire [5:0] pre_trig_idx;
    wire [5:0] pre_fault_idx;
    wire [6:0] pre_trig;
    wire [6:0] pre_fault;

    // Samples older than the history filled so far read as zero
    assign pre_trig_idx = hptr_q - `PF_PRE_TRIG_STEPS;
    assign pre_fault_idx = hptr_q - `PF_PRE_FAULT_STEPS;
    assign pre_trig = (hfill_q >= `PF_PRE_TRIG_STEPS) ?
        hist[pre_trig_idx] : 7'h00;
    assign pre_fault = (hfill_q >= `PF_PRE_FAULT_STEPS) ?
        hist[pre_fault_idx] : 7'h00;

    // One history entry per 5 ms step
    always @(posedge clk_in) begin
        if (tick_in) begin
            hist[hptr_q] <= pf_in;
        end
    end

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hptr_q <= 6'h00;
            hfill_q <= 6'h00;
        end else if (tick_in) begin
            hptr_q <= hptr_q + 6'h01;
            if (hfill_q != 6'h3F) begin
                hfill_q <= hfill_q + 6'h01;
            end
        end
    end

    // Record write: oldest entry is overwritten once twelve are held
    always @(posedge clk_in) begin
        if (wr_in) begin
            rec_pf[wptr_q] <= {pre_fault, pf_in, pre_trig};
            rec_info[wptr_q] <= {code_in, remain_in};
        end
    end

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wptr_q <= 4'h0;
            cnt_q <= 4'h0;
        end else if (wr_in) begin
            wptr_q <= (wptr_q == 4'hB) ? 4'h0 : wptr_q + 4'h1;
            if (cnt_q != 4'hC) begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    // Index 0 is the newest record
    wire [4:0] rsel = {1'b0, wptr_q} + 5'h0B - {1'b0, rd_idx_in};
    wire [3:0] ridx = (rsel >= 5'h0C) ? rsel[3:0] - 4'hC : rsel[3:0];
    wire rvalid = rd_idx_in < cnt_q;
    assign rd_pf_out = rvalid ? rec_pf[ridx] : 21'h000000;
    assign rd_info_out = {rvalid, rvalid ? rec_info[ridx] : 22'h000000};
    assign count_out = cnt_q;
endmodule // pf_record_store

// ---- core/pf_underlimit.v ----
// Power factor underlimit protection stage with Avalon-MM register slave
`timescale 1ns/1ps
`include "pf_consts.vh"
module pf_underlimit #(
    parameter STEP_CYCLES = `PF_STEP_CYCLES
) (
    input wire clk_in,
    input wire rstn_in,
    input wire [6:0] three_phase_pf_input_in,
    input wire block_in,
    input wire [7:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    output reg [31:0] avs_readdata_out,
    output reg avs_waitrequest_out,
    output reg start_out,
    output reg trip_out,
    output reg alarm_start_out,
    output reg alarm_out,
    output reg blocked_out,
    output reg [2:0] condition_out,
    output reg pf_event_block_valid_out,
    output reg [3:0] pf_event_block_code_out,
    output reg [31:0] pf_event_block_time_out
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations
    reg [31:0] step_cnt_q;
    reg tick_q;
    reg [31:0] stamp_q;
    reg [2:0] mode_q;
    reg alarms_en_q;
    reg force_en_q;
    reg [2:0] force_q;
    reg ln_vis_q;
    reg [6:0] trip_thr_q;
    reg [6:0] alarm_thr_q;
    reg [18:0] trip_dly_q;
    reg [18:0] alarm_dly_q;
    reg [18:0] rel_dly_q;
    reg [19:0] evt_sel_q;
    reg [3:0] rec_idx_q;
    reg [6:0] pf_q;
    reg pu_trip_q;
    reg pu_alarm_q;
    reg [18:0] top_cnt_q;
    reg [18:0] aop_cnt_q;
    reg [18:0] trel_cnt_q;
    reg [18:0] arel_cnt_q;
    reg [9:0] evt_pend_q;
    reg [4:0] prev_q;
    reg rec_wr_q;
    reg [2:0] rec_code_q;
    reg [2:0] cond_d;
    reg [31:0] rdata_d;
    reg [3:0] evt_code_d;
    integer i;
    wire [11:0] ratio_trip;
    wire [11:0] ratio_alarm;
    wire [20:0] rec_pf;
    wire [22:0] rec_info;
    wire [3:0] rec_cnt;
    wire blk_mode;
    wire run_mode;
    wire pu_trip_d;
    wire pu_alarm_d;
    wire blk_now;
    wire [4:0] cur_out;
    wire acc;

    // Pickup below threshold, release above 103 percent of it
    function pickup;
        input was_up;
        input [6:0] pf;
        input [6:0] thr;
        begin
            if (was_up) begin
                pickup = !({7'h00, pf} * 14'h0064 >
                    {7'h00, thr} * {7'h00, `PF_HYST_PCT});
            end else begin
                pickup = pf < thr;
            end
        end
    endfunction

    // Threshold writes outside 0.05..0.99 are clamped into range
    function [6:0] clamp_thr;
        input [6:0] v;
        begin
            if (v < `PF_THR_MIN) begin
                clamp_thr = `PF_THR_MIN;
            end else if (v > `PF_THR_MAX) begin
                clamp_thr = `PF_THR_MAX;
            end else begin
                clamp_thr = v;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Processing step: one tick every 5 ms, plus a free time stamp
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            step_cnt_q <= 32'h00000000;
            tick_q <= 1'b0;
            stamp_q <= 32'h00000000;
        end else begin
            tick_q <= (step_cnt_q == STEP_CYCLES - 1);
            if (step_cnt_q == STEP_CYCLES - 1) begin
                step_cnt_q <= 32'h00000000;
                stamp_q <= stamp_q + 32'h00000001;
            end else begin
                step_cnt_q <= step_cnt_q + 32'h00000001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pickup decisions for the present sample
    assign blk_mode = (mode_q == `PF_MODE_BLOCKED) ||
        (mode_q == `PF_MODE_TEST_BLK);
    assign run_mode = (mode_q != `PF_MODE_OFF);
    assign pu_trip_d = run_mode &&
        pickup(pu_trip_q, three_phase_pf_input_in, trip_thr_q);
    assign pu_alarm_d = run_mode && alarms_en_q &&
        pickup(pu_alarm_q, three_phase_pf_input_in, alarm_thr_q);
    assign blk_now = block_in || blk_mode;
    assign cur_out = {alarm_out, alarm_start_out, trip_out, start_out,
        blocked_out};

    // Definite time stages; release delay restarts operate timing
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pf_q <= 7'h00;
            pu_trip_q <= 1'b0;
            pu_alarm_q <= 1'b0;
            top_cnt_q <= 19'h00000;
            aop_cnt_q <= 19'h00000;
            trel_cnt_q <= 19'h00000;
            arel_cnt_q <= 19'h00000;
            start_out <= 1'b0;
            trip_out <= 1'b0;
            alarm_start_out <= 1'b0;
            alarm_out <= 1'b0;
            blocked_out <= 1'b0;
        end else if (tick_q) begin
            pf_q <= three_phase_pf_input_in;
            pu_trip_q <= pu_trip_d;
            pu_alarm_q <= pu_alarm_d;
            // Block sampled at step start wins over start
            blocked_out <= (pu_trip_d || pu_alarm_d) && blk_now;
            start_out <= pu_trip_d && !blk_now;
            alarm_start_out <= pu_alarm_d && !blk_now;
            if (pu_trip_d && !blk_now) begin
                trel_cnt_q <= 19'h00000;
                if (top_cnt_q < trip_dly_q) begin
                    top_cnt_q <= top_cnt_q + 19'h00001;
                end
                trip_out <= (top_cnt_q + 19'h00001 >= trip_dly_q);
            end else if (trel_cnt_q + 19'h00001 >= rel_dly_q) begin
                trel_cnt_q <= 19'h00000;
                top_cnt_q <= 19'h00000;
                trip_out <= 1'b0;
            end else begin
                trel_cnt_q <= trel_cnt_q + 19'h00001;
            end
            if (pu_alarm_d && !blk_now) begin
                arel_cnt_q <= 19'h00000;
                if (aop_cnt_q < alarm_dly_q) begin
                    aop_cnt_q <= aop_cnt_q + 19'h00001;
                end
                alarm_out <= (aop_cnt_q + 19'h00001 >= alarm_dly_q);
            end else if (arel_cnt_q + 19'h00001 >= rel_dly_q) begin
                arel_cnt_q <= 19'h00000;
                aop_cnt_q <= 19'h00000;
                alarm_out <= 1'b0;
            end else begin
                arel_cnt_q <= arel_cnt_q + 19'h00001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reported condition: forcing first, then trip before alarm
    always @* begin
        if (force_en_q) begin
            cond_d = force_q;
        end else if (trip_out) begin
            cond_d = `PF_ST_TRIP;
        end else if (alarm_out) begin
            cond_d = `PF_ST_ALARM;
        end else if (start_out) begin
            cond_d = `PF_ST_START;
        end else if (alarm_start_out) begin
            cond_d = `PF_ST_ALARM_START;
        end else if (blocked_out) begin
            cond_d = `PF_ST_BLOCKED;
        end else begin
            cond_d = `PF_ST_NORMAL;
        end
    end

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            condition_out <= `PF_ST_NORMAL;
        end else begin
            condition_out <= cond_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Events: edges captured after each step, emitted one per cycle
    // Code = 2*source + (0 ON, 1 OFF); source 0 block .. 4 alarm
    always @* begin
        evt_code_d = 4'h0;
        for (i = 9; i >= 0; i = i - 1) begin
            if (evt_pend_q[i]) begin
                evt_code_d = i[3:0];
            end
        end
    end

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            evt_pend_q <= 10'h000;
            prev_q <= 5'h00;
            pf_event_block_valid_out <= 1'b0;
            pf_event_block_code_out <= 4'h0;
            pf_event_block_time_out <= 32'h00000000;
            rec_wr_q <= 1'b0;
            rec_code_q <= `PF_ST_NORMAL;
        end else begin
            prev_q <= cur_out;
            rec_wr_q <= 1'b0;
            pf_event_block_valid_out <= (evt_pend_q != 10'h000);
            pf_event_block_code_out <= evt_code_d;
            pf_event_block_time_out <= stamp_q;
            for (i = 0; i < 5; i = i + 1) begin
                // New edges win over the clear of the one being sent
                evt_pend_q[2*i] <= (evt_pend_q[2*i] &&
                    !(evt_code_d == 2*i)) || (cur_out[i] && !prev_q[i] &&
                    evt_sel_q[2*i]);
                evt_pend_q[2*i+1] <= (evt_pend_q[2*i+1] &&
                    !(evt_code_d == 2*i+1)) || (!cur_out[i] && prev_q[i] &&
                    evt_sel_q[2*i+1]);
            end
            // Record on ON of trip, start or blocked
            if (trip_out && !prev_q[2]) begin
                rec_wr_q <= 1'b1;
                rec_code_q <= `PF_ST_TRIP;
            end else if (start_out && !prev_q[1]) begin
                rec_wr_q <= 1'b1;
                rec_code_q <= `PF_ST_START;
            end else if (blocked_out && !prev_q[0]) begin
                rec_wr_q <= 1'b1;
                rec_code_q <= `PF_ST_BLOCKED;
            end
        end
    end

    pf_record_store u_store (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .tick_in(tick_q),
        .pf_in(pf_q),
        .wr_in(rec_wr_q),
        .code_in(rec_code_q),
        .remain_in(trip_dly_q - top_cnt_q),
        .rd_idx_in(rec_idx_q),
        .rd_pf_out(rec_pf),
        .rd_info_out(rec_info),
        .count_out(rec_cnt)
    );

    ////////////////////////////////////////////////////////////////////////
    // Ratios recomputed each step from the live thresholds
    pf_ratio_div u_div_trip (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .start_in(tick_q),
        .pf_in(three_phase_pf_input_in),
        .thr_in(trip_thr_q),
        .ratio_out(ratio_trip)
    );

    pf_ratio_div u_div_alarm (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .start_in(tick_q),
        .pf_in(three_phase_pf_input_in),
        .thr_in(alarm_thr_q),
        .ratio_out(ratio_alarm)
    );

    ////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: one wait cycle, then the answer
    assign acc = (avs_read_in || avs_write_in) && !avs_waitrequest_out;

    always @* begin
        rdata_d = 32'h00000000;
        case (avs_address_in)
            `PF_REG_CTRL: begin
                rdata_d = {19'h00000, ln_vis_q, force_q, force_en_q,
                    3'h0, alarms_en_q, 1'b0, mode_q};
            end
            `PF_REG_TRIP_THR: rdata_d = {25'h0000000, trip_thr_q};
            `PF_REG_ALARM_THR: rdata_d = {25'h0000000, alarm_thr_q};
            `PF_REG_TRIP_DLY: rdata_d = {13'h0000, trip_dly_q};
            `PF_REG_ALARM_DLY: rdata_d = {13'h0000, alarm_dly_q};
            `PF_REG_REL_DLY: rdata_d = {13'h0000, rel_dly_q};
            `PF_REG_STATUS: begin
                rdata_d = {16'h0000, 1'b0, ln_vis_q ? mode_q : 3'h0,
                    1'b0, condition_out, 3'h0, cur_out};
            end
            `PF_REG_TTA: begin
                rdata_d = {13'h0000, alarm_start_out ?
                    alarm_dly_q - aop_cnt_q : 19'h00000};
            end
            `PF_REG_TTT: begin
                rdata_d = {{12{1'b0}}, start_out ? {1'b0, trip_dly_q} -
                    {1'b0, top_cnt_q} : 20'h00000};
                rdata_d[31:20] = {12{rdata_d[19]}};
            end
            `PF_REG_EXP_ALARM: rdata_d = {13'h0000, alarm_dly_q};
            `PF_REG_EXP_TRIP: rdata_d = {13'h0000, trip_dly_q};
            `PF_REG_RATIO_TRIP: rdata_d = {20'h00000, ratio_trip};
            `PF_REG_RATIO_ALARM: rdata_d = {20'h00000, ratio_alarm};
            `PF_REG_EVT_SEL: rdata_d = {12'h000, evt_sel_q};
            `PF_REG_REC_IDX: rdata_d = {24'h000000, rec_cnt, rec_idx_q};
            `PF_REG_REC_PF: rdata_d = {11'h000, rec_pf};
            `PF_REG_REC_INFO: rdata_d = {9'h000, rec_info};
            default: rdata_d = 32'h00000000;
        endcase
    end

    // Thresholds and delays take effect at the next step
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h00000000;
            mode_q <= `PF_MODE_ON;
            alarms_en_q <= 1'b1;
            force_en_q <= 1'b0;
            force_q <= `PF_ST_NORMAL;
            ln_vis_q <= 1'b0;
            trip_thr_q <= `PF_TRIP_THR_RST;
            alarm_thr_q <= `PF_ALARM_THR_RST;
            trip_dly_q <= `PF_TRIP_DLY_RST;
            alarm_dly_q <= `PF_ALARM_DLY_RST;
            rel_dly_q <= `PF_REL_DLY_RST;
            evt_sel_q <= `PF_EVT_SEL_RST;
            rec_idx_q <= 4'h0;
        end else begin
            avs_waitrequest_out <= !((avs_read_in || avs_write_in) &&
                avs_waitrequest_out);
            if (avs_read_in && avs_waitrequest_out) begin
                avs_readdata_out <= rdata_d;
            end
            if (acc && avs_write_in) begin
                case (avs_address_in)
                    `PF_REG_CTRL: begin
                        mode_q <= (avs_writedata_in[2:0] > `PF_MODE_OFF) ?
                            `PF_MODE_OFF : avs_writedata_in[2:0];
                        alarms_en_q <= avs_writedata_in[`PF_CTRL_ALARMS_BIT];
                        force_en_q <= avs_writedata_in[`PF_CTRL_FORCE_EN_BIT];
                        force_q <= (avs_writedata_in[11:9] > `PF_ST_ALARM) ?
                            `PF_ST_NORMAL : avs_writedata_in[11:9];
                        ln_vis_q <= avs_writedata_in[`PF_CTRL_LN_VIS_BIT];
                    end
                    `PF_REG_TRIP_THR: begin
                        trip_thr_q <= clamp_thr(avs_writedata_in[6:0]);
                    end
                    `PF_REG_ALARM_THR: begin
                        alarm_thr_q <= clamp_thr(avs_writedata_in[6:0]);
                    end
                    `PF_REG_TRIP_DLY: trip_dly_q <= avs_writedata_in[18:0];
                    `PF_REG_ALARM_DLY: alarm_dly_q <= avs_writedata_in[18:0];
                    `PF_REG_REL_DLY: rel_dly_q <= avs_writedata_in[18:0];
                    `PF_REG_EVT_SEL: evt_sel_q <= avs_writedata_in[19:0];
                    `PF_REG_REC_IDX: rec_idx_q <= avs_writedata_in[3:0];
                    default: begin
                    end
                endcase
            end
        end
    end
endmodule // pf_underlimit

// ---- verification/pf_source.sv ----
// Measurement path model feeding power factor samples
`timescale 1ns/1ps
module pf_source (
    input wire clk_in,
    input wire [6:0] want_in,
    output reg [6:0] pf_out
);
    // One register of lag, like a real averaging stage
    initial pf_out = 7'h64;
    always @(posedge clk_in) begin
        pf_out <= want_in;
    end
endmodule // pf_source

// ---- verification/pf_asserts.sv ----
// Port checker for the underlimit stage
`timescale 1ns/1ps
module pf_asserts #(parameter STEP_CYCLES = 20) (
    input wire clk_in,
    input wire rstn_in,
    input wire avs_read_in,
    input wire avs_waitrequest_out,
    input wire start_out,
    input wire trip_out,
    input wire alarm_start_out,
    input wire alarm_out,
    input wire blocked_out,
    input wire [2:0] condition_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    ////////////////////////////////////////////////////////////////////
    // Bus answer comes one cycle after taking and lasts one cycle
    rd_answer_a: assert property (avs_read_in && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("late read answer");
    wait_pulse_a: assert property (!avs_waitrequest_out
        |=> avs_waitrequest_out) else $error("long answer");
    cond_range_a: assert property (condition_out <= 3'h5)
        else $error("bad condition code");
    blk_excl_a: assert property (!(blocked_out && start_out))
        else $error("blocked with start");
    trip_blk_a: assert property ($rose(trip_out) |-> !blocked_out)
        else $error("trip while blocked");
    trip_cause_a: assert property ($rose(trip_out) |-> start_out)
        else $error("trip without start");
    alarm_cause_a: assert property ($rose(alarm_out)
        |-> alarm_start_out) else $error("alarm without start");
    // Outputs move only on steps, so they hold far longer than 8 cycles
    step_hold_a: assert property ($changed(start_out)
        |=> $stable(start_out)[*8]) else $error("start off step");
    cover property ($rose(trip_out));
    cover property ($rose(blocked_out));
    cover property ($rose(alarm_out));
endmodule // pf_asserts
bind pf_underlimit pf_asserts #(.STEP_CYCLES(STEP_CYCLES)) u_pf_asserts (
    .clk_in(clk_in), .rstn_in(rstn_in), .avs_read_in(avs_read_in),
    .avs_waitrequest_out(avs_waitrequest_out), .start_out(start_out),
    .trip_out(trip_out), .alarm_start_out(alarm_start_out),
    .alarm_out(alarm_out), .blocked_out(blocked_out),
    .condition_out(condition_out));

// ---- verification/tb.sv ----
// Self-checking bench for the underlimit stage
`timescale 1ns/1ps
module tb;
    localparam int STEP = 20;
    reg clk_in = 0, rstn_in = 0, block_in = 0;
    reg avs_read_in = 0, avs_write_in = 0;
    reg [7:0] avs_address_in = 8'h00;
    reg [31:0] avs_writedata_in = 32'h0;
    reg [6:0] pf_q = 7'h64;
    wire [6:0] pf_w;
    wire [31:0] avs_readdata_out;
    wire avs_waitrequest_out, start_out, ev_v;
    wire [3:0] ev_c;
    int n_errors = 0, cmp_count = 0, i, n_blk = 0;
    int pv[5] = '{40, 82, 83, 92, 93};
    int cv[5] = '{2, 2, 5, 5, 0};
    logic [31:0] exq[$], mkq[$], rs = 32'd40140;
    // Free-running 200 MHz clock
    always #2.5 clk_in = ~clk_in;
    pf_source u_pf_source (.clk_in(clk_in), .want_in(pf_q), .pf_out(pf_w));
    pf_underlimit #(.STEP_CYCLES(STEP)) u_pf_underlimit (.clk_in(clk_in),
        .rstn_in(rstn_in), .three_phase_pf_input_in(pf_w),
        .block_in(block_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in),
        .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .start_out(start_out),
        .trip_out(), .alarm_start_out(), .alarm_out(), .blocked_out(),
        .condition_out(), .pf_event_block_valid_out(ev_v),
        .pf_event_block_code_out(ev_c), .pf_event_block_time_out());
    ////////////////////////////////////////////////////////////////////
    function [31:0] xs(input [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    task cmp(input string nm, input [31:0] e, input [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // Holds the request until waitrequest is seen low; reads note a result
    task bus(bit w, [7:0] a, [31:0] d, [31:0] m = 32'hFFFFFFFF);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= w;
        avs_read_in <= !w;
        if (!w) begin
            exq.push_back(d);
            mkq.push_back(m);
        end
        @(posedge clk_in);
        while (avs_waitrequest_out !== 1'b0) @(posedge clk_in);
        avs_write_in <= 0;
        avs_read_in <= 0;
        @(posedge clk_in);
    endtask
    task step(input int n);
        repeat (n * STEP) @(posedge clk_in);
    endtask
    task stat(input [31:0] c);
        bus(0, 8'h18, c << 8, 32'h700);
    endtask
    task report_and_stop;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Read results are compared against the oldest note; block ON counted
    always @(posedge clk_in) begin
        if (avs_read_in && avs_waitrequest_out === 1'b0)
            cmp("rdata", exq.pop_front(), avs_readdata_out & mkq.pop_front());
        if (ev_v === 1'b1 && ev_c === 4'h0)
            n_blk++;
    end
    // Watchdog cuts a hang short
    initial begin
        #50000;
        n_errors++;
        report_and_stop;
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk_in);
        rstn_in <= 1;
        @(posedge clk_in);
        bus(0, 8'h04, 32'h50);
        bus(0, 8'h08, 32'h5A);
        bus(0, 8'h00, 32'h10);
        bus(0, 8'h7C, 32'h0);
        bus(1, 8'h04, 32'h1);
        bus(0, 8'h04, 32'h5);
        bus(1, 8'h04, 32'h7F);
        bus(0, 8'h04, 32'h63);
        bus(1, 8'h04, 32'h50);
        bus(1, 8'h0C, 32'h2);
        bus(1, 8'h10, 32'h3);
        bus(0, 8'h28, 32'h2);
        $display("done settings");
        for (i = 0; i < 5; i++) begin
            pf_q <= 7'(pv[i]);
            step(3);
            stat(cv[i]);
        end
        pf_q <= 7'd40;
        step(2);
        bus(0, 8'h2C, 32'd50);
        bus(0, 8'h30, 32'd44);
        bus(0, 8'h1C, 32'd1);
        $display("done pickup");
        block_in <= 1;
        step(3);
        stat(3);
        cmp("start", 0, start_out);
        cmp("blk_evt", 1, n_blk);
        block_in <= 0;
        for (i = 0; i < 6; i++) begin
            bus(1, 8'h00, 32'h1010 | i);
            bus(0, 8'h18, (i > 4 ? 4 : i) << 12, 32'h7000);
        end
        step(3);
        stat(0);
        for (i = 0; i < 7; i++) begin
            bus(1, 8'h00, 32'h110 | (i << 9));
            stat(i > 5 ? 0 : i);
        end
        bus(1, 8'h00, 32'h0);
        pf_q <= 7'd85;
        step(3);
        stat(0);
        bus(0, 8'h2C, 32'd106);
        repeat (4) begin
            rs = xs(rs);
            pf_q <= 7'd93 + rs[2:0];
            step(2);
            stat(0);
        end
        $display("done modes");
        report_and_stop;
    end
endmodule // tb
